// ### hw/clkdiv_consts.svh
// Purpose: shared constants of the clock divider and fanout block
// Assumes: included by bare name, definitions only
// Notes:   counts are in reference clock falling edges unless stated
`ifndef CLKDIV_CONSTS_SVH
`define CLKDIV_CONSTS_SVH

// divider counter width, enough for the largest ratio of 16
`define CDF_CNT_W        4
// reset value of the divider counter
`define CDF_CNT_RST      4'h0
// flip-flops in each pin synchroniser
`define CDF_SYNC_STAGES  2
// select field positions within the packed select bus
`define CDF_SEL_LO0      0
`define CDF_SEL_LO1      1
`define CDF_SEL_MSB      2
`define CDF_SEL_W        3
// counter bit that carries each divided clock
`define CDF_BIT_DIV2     0
`define CDF_BIT_DIV4     1
`define CDF_BIT_DIV8     2
`define CDF_BIT_DIV16    3
// reset values of the output legs and of the enable
`define CDF_TRUE_RST     1'b0
`define CDF_COMP_RST     1'b1
`define CDF_EN_RST       1'b0
// low select bits for each ratio
`define CDF_LO_DIV2      2'h0
`define CDF_LO_DIV4      2'h1
`define CDF_LO_DIV8      2'h2
`define CDF_LO_DIV16     2'h3

`endif

// ### hw/clkdiv_pkg.sv
// Purpose: types of the clock divider and fanout block
// Assumes: constants live in clkdiv_consts.svh
// Notes:   ratio modes are one-hot so a status port can show them directly
package clkdiv_pkg;

	// selected output ratio
	typedef enum logic [4:0] {
		MODE_PASS  = 5'b00001,
		MODE_DIV2  = 5'b00010,
		MODE_DIV4  = 5'b00100,
		MODE_DIV8  = 5'b01000,
		MODE_DIV16 = 5'b10000
	} ratio_mode_e;

endpackage

// ### hw/pin_sync.sv
// Purpose: multi-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   only the last stage is visible; the first stage feeds nothing but the next
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             srst,
	// raw pins and their synchronised copy
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_r [STAGES];

	// refuse chains too short to settle metastability
	if (STAGES < 2) begin : g_bad_stages
		$error("pin_sync needs at least two stages");
	end

	// shift chain; reset loads the idle level of the pins
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < STAGES; i++) stage_r[i] <= RST_VAL;
		end else begin
			stage_r[0] <= pin_in;
			for (int i = 1; i < STAGES; i++) stage_r[i] <= stage_r[i-1];
		end
	end

	assign sync_out = stage_r[STAGES-1];

endmodule // pin_sync

// ### hw/clock_divider_fanout.sv
// Purpose: programmable divider of a differential reference clock with a 1:2 differential fanout
// Assumes: the reference clock is well below half of the 200 MHz system clock, so it is
//          oversampled as a plain pin; select and clear pins are static or slow
// Notes:   the reference is sampled, so output edges carry up to one system clock of jitter
//
// Operation
// - the output clock is the reference divided by 2, 4, 8 or 16, or the reference passed through.
// - two differential pairs, each true and complement, carry the same output clock.
// - a low clear zeroes the divider counter at once, without waiting for a reference edge.
// - in pass-through the clear only enables or disables the outputs at the next reference falling edge.
// - select pins idle high, so with nothing driving them the block divides by 16.
// - with select msb 0 the reference passes through; with msb 1 the low bits 00..11 pick 2, 4, 8, 16.
// - while clear is low every true leg is low and every complement leg is high, except in pass-through up to the next reference falling edge.
// - the disable action takes effect on the next high-to-low reference transition; the counter clear does not wait for it.
`timescale 1ns/1ps
`include "clkdiv_consts.svh"

module clock_divider_fanout #(
	parameter int CNT_W       = `CDF_CNT_W,
	parameter int SYNC_STAGES = `CDF_SYNC_STAGES
) (
	// system clock and reset
	input  wire logic               clock,
	input  wire logic               srst,
	// differential reference clock pins
	input  wire logic               ref_in_p,
	input  wire logic               ref_in_n,
	// ratio select pins, pulled high outside
	input  wire logic               ratio_sel_bit0,
	input  wire logic               ratio_sel_bit1,
	input  wire logic               ratio_sel_bit2,
	// active-low clear and output disable pin
	input  wire logic               clear_n,
	// first output pair
	output logic                    out_a_p,
	output logic                    out_a_n,
	// second output pair
	output logic                    out_b_p,
	output logic                    out_b_n,
	// status
	output clkdiv_pkg::ratio_mode_e ratio_mode,
	output logic                    outputs_enabled
);

	// the largest ratio needs bit 3 of the counter
	if (CNT_W < `CDF_BIT_DIV16 + 1) begin : g_bad_cnt
		$error("counter too narrow for divide by 16");
	end

	// the synchronisers refuse short chains too; checking here names this block in the failure
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("pin synchronisers need at least two stages");
	end

	// synchronised pin levels
	logic [1:0]             ref_sync;
	logic [`CDF_SEL_W-1:0]  sel_sync;
	logic                   clear_n_sync;

	// held state
	logic                   ref_level_r;
	logic                   ref_level_nxt;
	logic [CNT_W-1:0]       count_r;
	logic [CNT_W-1:0]       count_nxt;
	logic                   enable_r;
	logic                   enable_nxt;
	clkdiv_pkg::ratio_mode_e mode_r;
	clkdiv_pkg::ratio_mode_e mode_nxt;
	logic                   out_a_p_r;
	logic                   out_a_n_r;
	logic                   out_b_p_r;
	logic                   out_b_n_r;
	logic                   true_nxt;

	// decode wires
	logic                   ref_differs;
	logic                   ref_fall;
	logic                   sel_msb;
	logic [1:0]             sel_lo;
	logic                   clk_selected;

	// both reference legs idle at their resting levels: true low, complement high
	pin_sync #(
		.WIDTH   (2),
		.STAGES  (SYNC_STAGES),
		.RST_VAL (2'h2)
	) u_ref_sync (
		.clock    (clock),
		.srst     (srst),
		.pin_in   ({ref_in_n, ref_in_p}),
		.sync_out (ref_sync)
	);

	// select pins rest high, as their pull-ups would leave them
	pin_sync #(
		.WIDTH   (`CDF_SEL_W),
		.STAGES  (SYNC_STAGES),
		.RST_VAL (3'h7)
	) u_sel_sync (
		.clock    (clock),
		.srst     (srst),
		.pin_in   ({ratio_sel_bit2, ratio_sel_bit1, ratio_sel_bit0}),
		.sync_out (sel_sync)
	);

	// clear rests released
	pin_sync #(
		.WIDTH   (1),
		.STAGES  (SYNC_STAGES),
		.RST_VAL (1'h1)
	) u_clear_sync (
		.clock    (clock),
		.srst     (srst),
		.pin_in   (clear_n),
		.sync_out (clear_n_sync)
	);

	// differential receive: the level only moves when the legs disagree, which rides
	// out the short window where both synchronised legs read equal during a crossing
	assign ref_differs   = ref_sync[0] ^ ref_sync[1];
	assign ref_level_nxt = ref_differs ? ref_sync[0] : ref_level_r;
	assign ref_fall      = ref_level_r & ~ref_level_nxt;

	// ratio decode from the select field
	assign sel_msb = sel_sync[`CDF_SEL_MSB];
	assign sel_lo  = {sel_sync[`CDF_SEL_LO1], sel_sync[`CDF_SEL_LO0]};

	// msb low forces pass-through whatever the low bits say; all ones gives divide by 16
	always_comb begin
		mode_nxt = clkdiv_pkg::MODE_DIV16;
		if (!sel_msb) begin
			mode_nxt = clkdiv_pkg::MODE_PASS;
		end else begin
			case (sel_lo)
				`CDF_LO_DIV2:  mode_nxt = clkdiv_pkg::MODE_DIV2;
				`CDF_LO_DIV4:  mode_nxt = clkdiv_pkg::MODE_DIV4;
				`CDF_LO_DIV8:  mode_nxt = clkdiv_pkg::MODE_DIV8;
				`CDF_LO_DIV16: mode_nxt = clkdiv_pkg::MODE_DIV16;
				default:       mode_nxt = clkdiv_pkg::MODE_DIV16;
			endcase
		end
	end

	// enable follows the clear pin only on a reference falling edge, in every mode
	assign enable_nxt = ref_fall ? clear_n_sync : enable_r;

	// counter: zeroed while clear is low with no reference edge needed; it counts falling
	// edges only once enabled, so the enabling edge itself leaves it at zero
	// a live select change leaves the count running, so one output period may come out short;
	// that is the price of never restarting the divider behind the user's back
	always_comb begin
		count_nxt = count_r;
		if (!clear_n_sync) begin
			count_nxt = CNT_W'(`CDF_CNT_RST);
		end else if (!enable_r) begin
			count_nxt = CNT_W'(`CDF_CNT_RST);
		end else if (ref_fall) begin
			count_nxt = count_r + CNT_W'(1);
		end
	end

	// pick the clock for the active mode; each counter bit halves the one below
	always_comb begin
		case (mode_r)
			clkdiv_pkg::MODE_PASS:  clk_selected = ref_level_r;
			clkdiv_pkg::MODE_DIV2:  clk_selected = count_r[`CDF_BIT_DIV2];
			clkdiv_pkg::MODE_DIV4:  clk_selected = count_r[`CDF_BIT_DIV4];
			clkdiv_pkg::MODE_DIV8:  clk_selected = count_r[`CDF_BIT_DIV8];
			clkdiv_pkg::MODE_DIV16: clk_selected = count_r[`CDF_BIT_DIV16];
			default:                clk_selected = `CDF_TRUE_RST;
		endcase
	end

	// disabled outputs park true low and complement high; the low start after release
	// comes from the zeroed counter in divide modes and from the just-fallen reference in pass-through
	assign true_nxt = enable_r & clk_selected;

	// input state
	always_ff @(posedge clock) begin
		if (srst) begin
			ref_level_r <= `CDF_TRUE_RST;
			mode_r      <= clkdiv_pkg::MODE_DIV16;
		end else begin
			ref_level_r <= ref_level_nxt;
			mode_r      <= mode_nxt;
		end
	end

	// divider state
	always_ff @(posedge clock) begin
		if (srst) begin
			count_r  <= CNT_W'(`CDF_CNT_RST);
			enable_r <= `CDF_EN_RST;
		end else begin
			count_r  <= count_nxt;
			enable_r <= enable_nxt;
		end
	end

	// both pairs register the same value so they leave with no skew between them
	always_ff @(posedge clock) begin
		if (srst) begin
			out_a_p_r <= `CDF_TRUE_RST;
			out_a_n_r <= `CDF_COMP_RST;
			out_b_p_r <= `CDF_TRUE_RST;
			out_b_n_r <= `CDF_COMP_RST;
		end else begin
			out_a_p_r <= true_nxt;
			out_a_n_r <= ~true_nxt;
			out_b_p_r <= true_nxt;
			out_b_n_r <= ~true_nxt;
		end
	end

	// outputs straight from flip-flops
	assign out_a_p         = out_a_p_r;
	assign out_a_n         = out_a_n_r;
	assign out_b_p         = out_b_p_r;
	assign out_b_n         = out_b_n_r;
	assign ratio_mode      = mode_r;
	assign outputs_enabled = enable_r;

endmodule // clock_divider_fanout

// ### tb/cdf_properties.sv
// Purpose: port assertions of the divider and fanout block
// Assumes: one clock domain, srst synchronous active high
// Notes:   HOLD must exceed one reference period plus the pin delay
`timescale 1ns/1ps
module cdf_properties #(
	parameter int HOLD = 64
) (
	// clock and reset
	input wire logic                    clock,
	input wire logic                    srst,
	// pins
	input wire logic                    ref_in_p,
	input wire logic                    ref_in_n,
	input wire logic                    ratio_sel_bit0,
	input wire logic                    ratio_sel_bit1,
	input wire logic                    ratio_sel_bit2,
	input wire logic                    clear_n,
	// outputs
	input wire logic                    out_a_p,
	input wire logic                    out_a_n,
	input wire logic                    out_b_p,
	input wire logic                    out_b_n,
	input wire clkdiv_pkg::ratio_mode_e ratio_mode,
	input wire logic                    outputs_enabled
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	logic [7:0] clr_cnt_r;
	logic [4:0] div_exp;
	// one-hot divided mode from the low select bits
	assign div_exp = 5'h02 << {ratio_sel_bit1, ratio_sel_bit0};
	// saturating count of cycles with clear held low
	always_ff @(posedge clock) begin
		if (srst || clear_n)
			clr_cnt_r <= 8'h00;
		else if (clr_cnt_r != 8'hFF)
			clr_cnt_r <= clr_cnt_r + 8'h01;
	end
	a_pairs_match: assert property (out_a_p == out_b_p && out_a_n == out_b_n)
		else $error("output pairs differ");
	a_legs_inverse: assert property (out_a_n == !out_a_p)
		else $error("complement leg not inverse");
	a_off_drives_low: assert property (!outputs_enabled && !$past(outputs_enabled) |-> !out_a_p && out_a_n)
		else $error("disabled outputs not low/high");
	a_clear_holds: assert property (clr_cnt_r >= HOLD |-> !outputs_enabled)
		else $error("outputs still enabled under clear");
	a_pass_decode: assert property (!ratio_sel_bit2 [*5] |-> ratio_mode == clkdiv_pkg::MODE_PASS)
		else $error("pass mode not decoded");
	a_div_decode: assert property ((ratio_sel_bit2 && $stable({ratio_sel_bit1, ratio_sel_bit0})) [*5]
		|-> ratio_mode == div_exp)
		else $error("divide mode not decoded");
	a_enable_cause: assert property ($changed(outputs_enabled)
		|-> outputs_enabled == $past(clear_n, 3) && !$past(ref_in_p, 2) && $past(ref_in_p, 6))
		else $error("enable moved off a reference fall");
	a_restart_low: assert property ($rose(outputs_enabled) |-> !out_a_p ##1 !out_a_p)
		else $error("output not low on restart");
	a_pass_follow: assert property ((ratio_mode == clkdiv_pkg::MODE_PASS && outputs_enabled) [*6]
		|-> out_a_p == $past(ref_in_p, 4) || out_a_p == $past(ref_in_p, 5))
		else $error("pass output not following reference");
	c_pass_run: cover property (ratio_mode == clkdiv_pkg::MODE_PASS && $rose(out_a_p));
	c_div16_run: cover property (ratio_mode == clkdiv_pkg::MODE_DIV16 && $rose(out_a_p));
	c_disable: cover property ($fell(outputs_enabled));
endmodule // cdf_properties
bind clock_divider_fanout cdf_properties i_props (.clock, .srst, .ref_in_p, .ref_in_n, .ratio_sel_bit0,
	.ratio_sel_bit1, .ratio_sel_bit2, .clear_n, .out_a_p, .out_a_n, .out_b_p, .out_b_n, .ratio_mode,
	.outputs_enabled);

// ### tb/ref_src.sv
// Purpose: free-running differential reference source
// Assumes: HALF system cycles per half period
// Notes:   legs change just after the system edge, never together with it
`timescale 1ns/1ps
module ref_src #(
	parameter int HALF = 10
) (
	// system clock
	input wire logic clock,
	// reference legs
	output logic     ref_p,
	output logic     ref_n
);
	int cnt = 0;
	// legs stay complementary so the input never reads equal
	initial begin
		ref_p = 1'b0;
		ref_n = 1'b1;
	end
	always @(posedge clock) begin
		cnt = cnt + 1;
		if (cnt == HALF) begin
			cnt = 0;
			#1 ref_p = !ref_p;
			ref_n = !ref_p;
		end
	end
endmodule // ref_src

// ### tb/testbench.sv
// Purpose: directed bench of the divider and fanout block
// Assumes: 200 MHz clock, reference of 20 clock periods
// Notes:   edge times carry one cycle of sampling slack
`timescale 1ns/1ps
module testbench;
	localparam int HALF = 10;
	localparam logic [2:0] SEL [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	localparam int DIV [6] = '{1, 1, 2, 4, 8, 16};
	localparam logic [4:0] MODE [6] = '{5'h01, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
	logic clock, srst, ref_p, ref_n, sel_oe, clear_n;
	logic out_a_p, out_a_n, out_b_p, out_b_n, outputs_enabled;
	logic [2:0] sel_v;
	tri1 [2:0] sel;
	clkdiv_pkg::ratio_mode_e ratio_mode;
	int miscompares = 0, n_checks = 0, cyc = 0, th, tp, t0, k;
	// undriven select pins float high
	assign sel = sel_oe ? sel_v : 3'hZ;
	ref_src #(.HALF(HALF)) i_ref (.clock, .ref_p, .ref_n);
	clock_divider_fanout i_dut (.clock, .srst, .ref_in_p(ref_p), .ref_in_n(ref_n), .ratio_sel_bit0(sel[0]),
		.ratio_sel_bit1(sel[1]), .ratio_sel_bit2(sel[2]), .clear_n, .out_a_p, .out_a_n, .out_b_p, .out_b_n,
		.ratio_mode, .outputs_enabled);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// cycle count doubles as the hang limit
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// wait for out_a_p (0), ref_p (1) or outputs_enabled (2) to reach v
	task automatic wait_on(input int w, input logic v);
		for (int i = 0; i < 2000 && (w == 0 ? out_a_p : w == 1 ? ref_p : outputs_enabled) !== v; i++)
			tick(1);
		// a wait that runs out is a mismatch, never a silent fall-through
		if ((w == 0 ? out_a_p : w == 1 ? ref_p : outputs_enabled) !== v)
			chk({31'h0, ~v}, {31'h0, v});
	endtask
	task automatic measure();
		wait_on(0, 1'b0);
		wait_on(0, 1'b1);
		t0 = cyc;
		wait_on(0, 1'b0);
		th = cyc - t0;
		wait_on(0, 1'b1);
		tp = cyc - t0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		clear_n = 1'b1;
		sel_oe = 1'b0;
		sel_v = 3'h7;
		tick(8);
		srst = 1'b0;
		tick(4);
		chk(ratio_mode, clkdiv_pkg::MODE_DIV16);
		measure();
		chk(tp, 32 * HALF);
		sel_oe = 1'b1;
		// select codes 0, 3, 4, 5, 6 and 7: mode, period and high time
		for (k = 0; k < 6; k++) begin
			sel_v = SEL[k];
			measure();
			measure();
			chk(ratio_mode, MODE[k]);
			chk(tp, 2 * DIV[k] * HALF);
			chk(th, DIV[k] * HALF);
		end
		// short clear between reference falls: counter zeroes, enable stays
		wait_on(0, 1'b1);
		tick(40);
		clear_n = 1'b0;
		tick(4);
		clear_n = 1'b1;
		tick(6);
		chk(out_a_p, 1'b0);
		chk(outputs_enabled, 1'b1);
		// long clear in pass-through and in divide by 4
		for (k = 0; k < 2; k++) begin
			sel_v = k ? 3'h5 : 3'h0;
			measure();
			wait_on(1, 1'b1);
			clear_n = 1'b0;
			wait_on(2, 1'b0);
			chk(ref_p, 1'b0);
			sel_v = 3'h6;
			tick(40);
			chk({out_a_p, out_a_n, out_b_p, out_b_n}, 4'h5);
			sel_v = k ? 3'h5 : 3'h0;
			tick(30);
			wait_on(1, 1'b1);
			clear_n = 1'b1;
			wait_on(2, 1'b1);
			chk(ref_p, 1'b0);
			t0 = cyc;
			wait_on(0, 1'b1);
			chk(cyc - t0 >= (k ? 4 : 1) * HALF && cyc - t0 <= (k ? 4 : 1) * HALF + 2, 1'b1);
		end
		wrap_up();
	end
endmodule // testbench
